// *** psd_defs.svh ***
//------------------------------------------------------------------------------
// Functional notes
// - Each serial clock rising edge shifts one data bit into a 24-bit register.
// - Words arrive most significant bit first; first bit lands in bit 23.
// - Load strobe rising edge copies the shift register into one holding latch; select 11 loads none.
// - The destination comes from bits 1 (high select) and 0 (low select).
// - Select 00 reference, 01 feedback, 10 function word with prescaler.
// - Reference input divides by a 14-bit ratio of 1 to 16383.
// - Main feedback counter is 13-bit, ratio 1 to 8191.
// - Swallow counter is 6-bit, value 0 to 63.
// - RF passes a fixed divide-by-4; total ratio is 4(B*P+A).
// - Software picks prescaler pair 8/9, 16/17, 32/33 or 64/65.
// - Lock goes high after five consecutive comparisons with error below 15 ns.
// - Lock stays high until a comparison shows error above 25 ns.
// - A three-bit function field selects the monitor output source, lock included.
// - Phase comparator compares reference divider output with feedback divider output.
// - Counter clear bit set holds reference and feedback dividers in reset.
// - Chip enable low disables the device once through the two-stage pin synchroniser, whatever the sleep bit.
// - In any power-down the serial input register still shifts and latches.
//------------------------------------------------------------------------------
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

// Word layout
`define PSD_WORD_W       24
`define PSD_SEL_MSB      1
`define PSD_SEL_LSB      0
`define PSD_SEL_REF      2'h0
`define PSD_SEL_FB       2'h1
`define PSD_SEL_FUNC     2'h2
`define PSD_REF_MSB      15
`define PSD_REF_LSB      2
`define PSD_SWAL_MSB     7
`define PSD_SWAL_LSB     2
`define PSD_MAIN_MSB     20
`define PSD_MAIN_LSB     8
`define PSD_CLEAR_BIT    2
`define PSD_SLEEP_BIT    3
`define PSD_MON_MSB      6
`define PSD_MON_LSB      4
`define PSD_PRE_MSB      23
`define PSD_PRE_LSB      22

// Prescaler moduli
`define PSD_PRE_SEL_8    2'h0
`define PSD_PRE_SEL_16   2'h1
`define PSD_PRE_SEL_32   2'h2
`define PSD_MOD_8        7'h08
`define PSD_MOD_16       7'h10
`define PSD_MOD_32       7'h20
`define PSD_MOD_64       7'h40
`define PSD_FIX_DIV_LAST 2'h3

// Monitor source codes
`define PSD_MON_LOW      3'h0
`define PSD_MON_LOCK     3'h1
`define PSD_MON_FB       3'h2
`define PSD_MON_HIGH     3'h3
`define PSD_MON_REF      3'h4

// Pin synchroniser lanes
`define PSD_PINS         6
`define PSD_PIN_SCLK     0
`define PSD_PIN_SDATA    1
`define PSD_PIN_LOAD     2
`define PSD_PIN_REF      3
`define PSD_PIN_RF       4
`define PSD_PIN_CE       5

// Lock detect timing
`define PSD_CLK_NS       40
`define PSD_LOCK_ERR_NS  15
`define PSD_UNLOCK_ERR_NS 25
`define PSD_LOCK_ERR_CYC   ((`PSD_LOCK_ERR_NS + `PSD_CLK_NS - 1) / `PSD_CLK_NS)
`define PSD_UNLOCK_ERR_CYC ((`PSD_UNLOCK_ERR_NS / `PSD_CLK_NS) + 1)
`define PSD_LOCK_RUN     3'h5
`define PSD_ERR_MAX      8'hff

`endif

// *** psd_pkg.sv ***
package psd_pkg;

    // Three-wire programming pins
    typedef struct packed {
        logic sclk;
        logic sdata;
        logic load_strobe;
    } psd_serial_s;

    // Phase comparator states
    typedef enum logic [1:0] {
        PSD_PC_IDLE     = 2'h0,
        PSD_PC_REF_LEAD = 2'h1,
        PSD_PC_FB_LEAD  = 2'h3
    } psd_pc_e;

    // Reference divider state
    typedef struct packed {
        logic [13:0] cnt;
        logic        pulse;
    } psd_rdiv_s;

    // Top-level state
    typedef struct packed {
        logic [5:0]  sync1;
        logic [5:0]  sync2;
        logic [5:0]  prev;
        logic [23:0] shift;
        logic [23:0] reference_divider_word;
        logic [23:0] feedback_divider_word;
        logic [23:0] function_control_word;
        logic [1:0]  div4;
        logic [6:0]  pres_cnt;
        logic [5:0]  swal_left;
        logic [12:0] main_left;
        logic        fb_pulse;
        psd_pc_e     pc;
        logic [7:0]  err_cnt;
        logic [2:0]  good_run;
        logic        locked;
        logic        pump_up;
        logic        pump_down;
        logic        monitor_output;
    } psd_top_s;

endpackage

// *** psd_ref_div.sv ***
`timescale 1ns/1ps
`include "psd_defs.svh"

module psd_ref_div
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Control
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic [13:0] ratio,
    // Divided output
    output logic             pulse
);
    import psd_pkg::*;

    psd_rdiv_s st;
    psd_rdiv_s next_st;

    // Down counter; ratio 0 behaves as 1 so the comparator never starves
    always_comb
    begin
        next_st       = st;
        next_st.pulse = 1'b0;
        if (!run)
        begin
            next_st.cnt = ratio;
        end
        else if (tick)
        begin
            if (st.cnt <= 14'h1)
            begin
                next_st.cnt   = ratio;
                next_st.pulse = 1'b1;
            end
            else
            begin
                next_st.cnt = st.cnt - 14'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pulse = st.pulse;

endmodule

// *** psd_top.sv ***
`timescale 1ns/1ps
`include "psd_defs.svh"

module psd_top
(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst_b,
    // Three-wire programming port
    input  wire psd_pkg::psd_serial_s serial_in,
    // Divider inputs and chip enable pins
    input  wire logic                ref_input_pin,
    input  wire logic                rf_input_pin,
    input  wire logic                chip_enable,
    // Outputs
    output logic                     monitor_output,
    output logic                     pump_up,
    output logic                     pump_down
);
    import psd_pkg::*;

    psd_top_s    st;
    psd_top_s    next_st;
    logic [5:0]  pins;
    logic [5:0]  rise;
    logic        active;
    logic        ref_pulse;
    logic [6:0]  modulus;
    logic [13:0] ref_ratio;

    //--------------------------------------------------------------------------
    // Pin gathering and edge detection
    //--------------------------------------------------------------------------

    // Lanes read only after the second synchroniser stage
    always_comb
    begin
        pins                 = '0;
        pins[`PSD_PIN_SCLK]  = serial_in.sclk;
        pins[`PSD_PIN_SDATA] = serial_in.sdata;
        pins[`PSD_PIN_LOAD]  = serial_in.load_strobe;
        pins[`PSD_PIN_REF]   = ref_input_pin;
        pins[`PSD_PIN_RF]    = rf_input_pin;
        pins[`PSD_PIN_CE]    = chip_enable;
    end

    assign rise      = st.sync2 & ~st.prev;
    // Chip enable low disables whatever the sleep bit; no edge needed, level acts after the two-stage synchroniser
    assign active    = st.sync2[`PSD_PIN_CE]
                     & ~st.function_control_word[`PSD_SLEEP_BIT]
                     & ~st.function_control_word[`PSD_CLEAR_BIT];
    assign ref_ratio = st.reference_divider_word[`PSD_REF_MSB:`PSD_REF_LSB];

    // Prescaler modulus
    always_comb
    begin
        case (st.function_control_word[`PSD_PRE_MSB:`PSD_PRE_LSB])
            `PSD_PRE_SEL_8:  modulus = `PSD_MOD_8;
            `PSD_PRE_SEL_16: modulus = `PSD_MOD_16;
            `PSD_PRE_SEL_32: modulus = `PSD_MOD_32;
            default:         modulus = `PSD_MOD_64;
        endcase
    end

    //--------------------------------------------------------------------------
    // Reference divider
    //--------------------------------------------------------------------------

    psd_ref_div u_ref_div
    (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (rise[`PSD_PIN_REF]),
        .run   (active),
        .ratio (ref_ratio),
        .pulse (ref_pulse)
    );

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------

    always_comb
    begin
        logic       term;
        logic       judge;
        logic [7:0] err;
        term  = 1'b0;
        judge = 1'b0;
        err   = '0;

        next_st          = st;
        next_st.sync1    = pins;
        next_st.sync2    = st.sync1;
        next_st.prev     = st.sync2;
        next_st.fb_pulse = 1'b0;

        // Serial path ignores power-down entirely
        if (rise[`PSD_PIN_SCLK])
        begin
            next_st.shift = {st.shift[`PSD_WORD_W-2:0], st.sync2[`PSD_PIN_SDATA]};
        end
        if (rise[`PSD_PIN_LOAD])
        begin
            case (st.shift[`PSD_SEL_MSB:`PSD_SEL_LSB])
                `PSD_SEL_REF:  next_st.reference_divider_word = st.shift;
                `PSD_SEL_FB:   next_st.feedback_divider_word  = st.shift;
                `PSD_SEL_FUNC: next_st.function_control_word  = st.shift;
                default:       next_st.shift                  = st.shift;
            endcase
        end

        // Feedback divider: fixed /4, dual modulus, swallow and main counters
        if (!active)
        begin
            next_st.div4      = '0;
            next_st.pres_cnt  = '0;
            next_st.swal_left = st.feedback_divider_word[`PSD_SWAL_MSB:`PSD_SWAL_LSB];
            next_st.main_left = st.feedback_divider_word[`PSD_MAIN_MSB:`PSD_MAIN_LSB];
        end
        else if (rise[`PSD_PIN_RF])
        begin
            next_st.div4 = st.div4 + 2'h1;
            if (st.div4 == `PSD_FIX_DIV_LAST)
            begin
                // P+1 while swallowing, P afterwards
                term = (st.swal_left != 6'h0) ? (st.pres_cnt == modulus)
                                              : (st.pres_cnt == modulus - 7'h1);
                next_st.pres_cnt = term ? 7'h0 : st.pres_cnt + 7'h1;
                if (term)
                begin
                    if (st.main_left <= 13'h1)
                    begin
                        next_st.fb_pulse  = 1'b1;
                        next_st.swal_left = st.feedback_divider_word[`PSD_SWAL_MSB:`PSD_SWAL_LSB];
                        next_st.main_left = st.feedback_divider_word[`PSD_MAIN_MSB:`PSD_MAIN_LSB];
                    end
                    else
                    begin
                        next_st.main_left = st.main_left - 13'h1;
                        if (st.swal_left != 6'h0)
                        begin
                            next_st.swal_left = st.swal_left - 6'h1;
                        end
                    end
                end
            end
        end

        // Phase comparator: error measured in clock cycles between the edges
        case (st.pc)
            PSD_PC_IDLE:
            begin
                if (ref_pulse && st.fb_pulse)
                begin
                    judge = 1'b1;
                end
                else if (ref_pulse)
                begin
                    next_st.pc      = PSD_PC_REF_LEAD;
                    next_st.err_cnt = 8'h1;
                    next_st.pump_up = 1'b1;
                end
                else if (st.fb_pulse)
                begin
                    next_st.pc        = PSD_PC_FB_LEAD;
                    next_st.err_cnt   = 8'h1;
                    next_st.pump_down = 1'b1;
                end
            end
            PSD_PC_REF_LEAD, PSD_PC_FB_LEAD:
            begin
                if (st.err_cnt != `PSD_ERR_MAX)
                begin
                    next_st.err_cnt = st.err_cnt + 8'h1;
                end
                if (ref_pulse || st.fb_pulse)
                begin
                    // A second leading edge also ends the cycle, as a gross error
                    judge = 1'b1;
                    err   = st.err_cnt;
                    next_st.pc        = PSD_PC_IDLE;
                    next_st.pump_up   = 1'b0;
                    next_st.pump_down = 1'b0;
                end
            end
            default:
            begin
                next_st.pc = PSD_PC_IDLE;
            end
        endcase

        // Lock detect with hysteresis
        if (judge)
        begin
            if (err < 8'(`PSD_LOCK_ERR_CYC))
            begin
                if (st.good_run + 3'h1 >= `PSD_LOCK_RUN)
                begin
                    next_st.locked = 1'b1;
                end
                else
                begin
                    next_st.good_run = st.good_run + 3'h1;
                end
            end
            else
            begin
                next_st.good_run = '0;
                if (err >= 8'(`PSD_UNLOCK_ERR_CYC))
                begin
                    next_st.locked = 1'b0;
                end
            end
        end

        // Power-down resets comparator and lock detect, not the latches
        if (!active)
        begin
            next_st.pc        = PSD_PC_IDLE;
            next_st.err_cnt   = '0;
            next_st.good_run  = '0;
            next_st.locked    = 1'b0;
            next_st.pump_up   = 1'b0;
            next_st.pump_down = 1'b0;
        end

        // Monitor output source
        case (st.function_control_word[`PSD_MON_MSB:`PSD_MON_LSB])
            `PSD_MON_LOCK: next_st.monitor_output = next_st.locked;
            `PSD_MON_FB:   next_st.monitor_output = st.fb_pulse;
            `PSD_MON_HIGH: next_st.monitor_output = 1'b1;
            `PSD_MON_REF:  next_st.monitor_output = ref_pulse;
            default:       next_st.monitor_output = 1'b0;
        endcase
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st    <= '0;
            st.pc <= PSD_PC_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign monitor_output = st.monitor_output;
    assign pump_up        = st.pump_up;
    assign pump_down      = st.pump_down;

endmodule

// *** psd_chk.sv ***
`timescale 1ns/1ps

module psd_chk
(
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst_b,
    // Watched pins
    input wire psd_pkg::psd_serial_s serial_in,
    input wire logic                 chip_enable,
    input wire logic                 monitor_output,
    input wire logic                 pump_up,
    input wire logic                 pump_down
);
    import psd_pkg::*;

    // ----------------------------------------
    // Shadow of the function word
    // ----------------------------------------
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  s3;
    logic [23:0] sh;
    logic [23:0] fw;
    logic [2:0]  hold;
    logic [2:0]  ce_cnt;
    logic [2:0]  msel;

    assign msel = fw[6:4];

    // Same sync depth as the pins inside, so the shadow never runs ahead
    always_ff @(posedge clock)
    begin
        s1 <= {serial_in.sclk, serial_in.sdata, serial_in.load_strobe};
        s2 <= s1;
        s3 <= s2;
        hold <= (hold == 3'h7) ? hold : hold + 3'h1;
        ce_cnt <= chip_enable ? 3'h0 : ((ce_cnt == 3'h7) ? ce_cnt : ce_cnt + 3'h1);
        if (s2[2] && !s3[2])
            sh <= {sh[22:0], s2[1]};
        if (s2[0] && !s3[0] && sh[1:0] == 2'h2)
        begin
            fw <= sh;
            hold <= 3'h0;
        end
        if (!rst_b)
        begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            s3 <= 3'h0;
            sh <= 24'h0;
            fw <= 24'h0;
            hold <= 3'h0;
            ce_cnt <= 3'h0;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    pump_excl_a: assert property (!(pump_up && pump_down))
        else $error("both pump outputs high");
    mon_high_a: assert property (hold >= 3'h3 && msel == 3'h3 |-> monitor_output)
        else $error("monitor not high for code 3");
    mon_low_a: assert property (hold >= 3'h3 && (msel == 3'h0 || msel >= 3'h5) |-> !monitor_output)
        else $error("monitor not low for low code");
    clear_quiet_a: assert property (hold >= 3'h3 && fw[2] |-> !pump_up && !pump_down)
        else $error("pumps active while counters cleared");
    clear_unlock_a: assert property (hold >= 3'h3 && fw[2] && msel == 3'h1 |-> !monitor_output)
        else $error("lock shown while counters cleared");
    ce_quiet_a: assert property (ce_cnt >= 3'h5 |-> !pump_up && !pump_down)
        else $error("pumps active with chip disabled");
    ce_unlock_a: assert property (ce_cnt >= 3'h5 && hold >= 3'h3 && msel == 3'h1 |-> !monitor_output)
        else $error("lock shown with chip disabled");
    ref_pulse_a: assert property (hold >= 3'h3 && msel == 3'h4 && monitor_output |=> !monitor_output)
        else $error("reference pulse longer than one cycle");
    fb_pulse_a: assert property (hold >= 3'h3 && msel == 3'h2 && monitor_output |=> !monitor_output)
        else $error("feedback pulse longer than one cycle");
endmodule

// *** psd_host.sv ***
`timescale 1ns/1ps

module psd_host
(
    // Control from the bench
    input  wire logic        clock,
    input  wire logic [23:0] word,
    input  wire logic        go,
    // Serial pins
    output psd_pkg::psd_serial_s pins,
    output logic             busy
);
    // Bit-bangs one word, each pin phase held 3 clocks to beat the synchroniser
    initial
    begin
        pins = '0;
        busy = 1'b0;
        forever
        begin
            @(negedge clock);
            if (go)
            begin
                busy = 1'b1;
                for (int i = 23; i >= 0; i--)
                begin
                    pins.sdata = word[i];
                    pins.sclk = 1'b0;
                    repeat (3) @(negedge clock);
                    pins.sclk = 1'b1;
                    repeat (3) @(negedge clock);
                end
                pins.sclk = 1'b0;
                pins.sdata = ~pins.sdata; // Released data shows no stale bit
                repeat (3) @(negedge clock);
                pins.load_strobe = 1'b1;
                repeat (3) @(negedge clock);
                pins.load_strobe = 1'b0;
                repeat (3) @(negedge clock);
                busy = 1'b0;
            end
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps

module testbench;
    import psd_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clock;
    logic        rst_b;
    logic        chip_enable;
    logic        wave;
    logic        wave_ph;
    logic [23:0] hw;
    logic        hgo;
    logic        busy;
    logic        monitor_output;
    logic        pump_up;
    logic        pump_down;
    psd_serial_s serial_in;
    int          rise_cnt;
    int          error_cnt;
    int          compares;
    int          seed;
    int          n0;
    int          a;
    int          b;
    int          r;

    psd_top u_dut (.clock(clock), .rst_b(rst_b), .serial_in(serial_in), .ref_input_pin(wave),
        .rf_input_pin(wave), .chip_enable(chip_enable), .monitor_output(monitor_output),
        .pump_up(pump_up), .pump_down(pump_down));
    psd_host u_host (.clock(clock), .word(hw), .go(hgo), .pins(serial_in), .busy(busy));

    // Clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Shared input wave, high and low two clocks each; far below the counter limit
    always @(negedge clock)
    begin
        wave_ph <= !wave_ph;
        if (wave_ph)
        begin
            wave <= !wave;
            if (!wave)
                rise_cnt <= rise_cnt + 1;
        end
    end

    function automatic int exp_fb(input int p, input int bb, input int aa);
        return 4 * (bb * (8 << p) + aa);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic send(input logic [23:0] w);
        hw <= w;
        hgo <= 1'b1;
        @(negedge clock);
        hgo <= 1'b0;
        @(negedge clock);
        for (int t = 0; t < 400 && busy; t++)
            @(negedge clock);
        repeat (6) @(negedge clock);
    endtask

    task automatic wait_mon(input logic lvl);
        for (int t = 0; t < 9000 && monitor_output !== lvl; t++)
            @(negedge clock);
    endtask

    // Skips two periods so a freshly loaded ratio has taken over
    task automatic measure(input int exp_n);
        repeat (2)
        begin
            wait_mon(1'b1);
            wait_mon(1'b0);
        end
        wait_mon(1'b1);
        @(posedge clock);
        n0 = rise_cnt;
        wait_mon(1'b0);
        wait_mon(1'b1);
        @(posedge clock);
        chk(rise_cnt - n0, exp_n);
    endtask

    // Watchdog
    initial
    begin
        repeat (90000) @(posedge clock);
        error_cnt++;
        wrap_up();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        seed = 10773;
        rst_b = 1'b0;
        chip_enable = 1'b1;
        wave = 1'b0;
        wave_ph = 1'b0;
        hw = 24'h0;
        hgo = 1'b0;
        rise_cnt = 0;
        error_cnt = 0;
        compares = 0;
        repeat (20) @(negedge clock);
        rst_b <= 1'b1;
        // Static monitor codes, then a select-11 word that must change nothing
        for (int i = 0; i < 6; i++)
        begin
            r = (i == 1 || i == 5) ? 3 : (i == 0 ? 0 : i + 3);
            send({17'h0, r[2:0], 2'h0, 2'h2});
            chk(monitor_output, r == 3);
        end
        send({17'h0, 3'h0, 2'h0, 2'h3});
        chk(monitor_output, 1'b1);
        // Feedback ratio for every prescaler pair
        for (int p = 0; p < 4; p++)
        begin
            // Swallow count kept at or below the main count, else some ratios are unreachable
            a = (p == 0) ? 0 : ($random(seed) & 3);
            b = 3 + ($random(seed) & 1);
            send({3'h0, b[12:0], a[5:0], 2'h1});
            send({p[1:0], 15'h0, 3'h2, 2'h0, 2'h2});
            measure(exp_fb(p, b, a));
        end
        // Reference ratio, smallest value first
        send({17'h0, 3'h4, 2'h0, 2'h2});
        for (int i = 0; i < 3; i++)
        begin
            r = (i == 0) ? 1 : 1 + ($random(seed) & 31);
            send({8'h0, r[13:0], 2'h0});
            measure(r);
        end
        // Lock with both dividers at 64 on one source, started by clear release
        send({17'h0, 3'h1, 2'h1, 2'h2});
        send({8'h0, 14'd64, 2'h0});
        send({3'h0, 13'd2, 6'd0, 2'h1});
        send({17'h0, 3'h1, 2'h0, 2'h2});
        wait_mon(1'b1);
        chk(monitor_output, 1'b1);
        send({8'h0, 14'd65, 2'h0});
        wait_mon(1'b0);
        chk(monitor_output, 1'b0);
        // Chip disabled: serial port still loads words
        chip_enable <= 1'b0;
        send({17'h0, 3'h3, 2'h0, 2'h2});
        chk(monitor_output, 1'b1);
        chip_enable <= 1'b1;
        wrap_up();
    end
endmodule

bind psd_top psd_chk u_chk (.clock(clock), .rst_b(rst_b), .serial_in(serial_in), .chip_enable(chip_enable),
    .monitor_output(monitor_output), .pump_up(pump_up), .pump_down(pump_down));
